/* File: hw/sftr_consts.vh */
// constants for the serial frame transmit/receive datapath
`ifndef SFTR_CONSTS_VH
`define SFTR_CONSTS_VH
// register byte offsets
`define SFTR_OFF_RXLOW     6'h00
`define SFTR_OFF_RXHIGH    6'h04
`define SFTR_OFF_TXLOW     6'h08
`define SFTR_OFF_TXHIGH    6'h0C
`define SFTR_OFF_STATUS    6'h10
`define SFTR_OFF_CTRLB     6'h14
`define SFTR_OFF_CTRLC     6'h18
`define SFTR_OFF_BAUD      6'h1C
`define SFTR_OFF_PINCTRL   6'h20
// field positions
`define SFTR_ST_RXC        7
`define SFTR_ST_TXC        6
`define SFTR_ST_DRE        5
`define SFTR_HI_PARERR     1
`define SFTR_HI_FRMERR     2
`define SFTR_HI_OVF        3
`define SFTR_CB_TXEN       0
`define SFTR_CB_RXEN       1
`define SFTR_CC_STOP2      3
`define SFTR_CC_SYNC       6
`define SFTR_PC_INV        0
`define SFTR_PC_XCKOUT     1
// character size codes
`define SFTR_CH_9LOWFIRST  3'h6
// parity modes
`define SFTR_PAR_EVEN      2'h2
`define SFTR_PAR_ODD       2'h3
// receive mode code for double speed
`define SFTR_RXM_DOUBLE    2'h1
// reset values
`define SFTR_RST_CTRLB     8'h00
`define SFTR_RST_CTRLC     8'h03
`define SFTR_RST_BAUD      16'h0040
`define SFTR_RST_PINCTRL   8'h00
// samples per bit, and the baud accumulator step per clock
`define SFTR_S_NORMAL      5'h10
`define SFTR_S_DOUBLE      5'h08
`define SFTR_S_SYNC        5'h02
`define SFTR_BAUD_ONE      17'h0_0040
`endif

/* File: hw/sftr_datapath.v */
// serial frame transmit/receive datapath with avalon-mm register slave
`timescale 1ns/1ps
`include "sftr_consts.vh"

// Behaviour
// - sixteen, eight or two samples per bit
// - buffer write starts frame via shift register
// - frame done, buffer empty sets transmit complete
// - empty flag shows buffer free for writing
// - short characters drop upper written bits
// - transmitter disable waits for frames to drain
// - disabled transmitter releases pin as input
// - shift bits until first stop, ignore second
// - first stop moves frame, sets receive complete
// - unused upper received bits read zero
// - error flags stored with their frame
// - low location read advances receive buffer
// - nine-bit low-first: high read advances instead
// - overflow flag when full buffer overwritten
// - parity checked against received parity bit
// - receiver disable flushes buffer, drops frame
// - one double-speed and three normal receive modes
// - clock pin direction selects master or slave
// - sample on edge opposite transmit edge
// - no inversion: launch rising, sample falling
// - inversion: launch falling, sample rising
// - start, 5-9 data, parity, 1-2 stops
// - two-entry receive buffer, one transmit buffer
// - async start accepted on two of three lows, sync start on one low sample
module sftr_datapath (
   input  wire        sys_clk,
   input  wire        rstn,
   input  wire [5:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   input  wire        rxdIn,
   output wire        txdOut,
   output wire        txdOe,
   input  wire        tclkIn,
   output wire        tclkOut,
   output wire        tclkOe
);
   localparam RX_IDLE = 3'd0, RX_START = 3'd1, RX_DATA = 3'd2, RX_PAR = 3'd3, RX_STOP = 3'd4;

   function [3:0] charBits;
      input [2:0] cs;
      charBits = (cs < 3'h4) ? {1'b0, cs} + 4'h5 : 4'h9;
   endfunction

   function [12:0] txFrame;
      input [8:0] d;
      input [2:0] cs;
      input [1:0] pm;
      integer i;
      reg     [3:0] n;
      reg           p;
      begin
         n = charBits(cs);
         txFrame = 13'h1FFF;
         txFrame[0] = 1'b0;
         p = pm[0];
         for (i = 0; i < 9; i = i + 1) begin
            if (i < n) begin
               txFrame[i + 1] = d[i];
               p = p ^ d[i];
            end
         end
         if (pm[1])
            txFrame[n + 1] = p;
      end
   endfunction

   reg [7:0]  ctrlB_r, ctrlC_r, pinCtrl_r;
   reg [15:0] baud_r;
   reg [16:0] baudAcc_r;
   reg        rdAck_r;
   reg        rxA_r, rxB_r, tclkA_r, tclkB_r, tclkPrev_r, tclkGen_r;
   reg [8:0]  txBuf_r;
   reg        txBufFull_r, txBusy_r, txc_r;
   reg [12:0] txSh_r;
   reg [3:0]  txCnt_r;
   reg [4:0]  txPh_r;
   reg [2:0]  rxState_r;
   reg [4:0]  rxPh_r;
   reg [1:0]  rxOnes_r;
   reg [3:0]  rxIdx_r;
   reg [8:0]  rxSh_r;
   reg        rxPar_r, rxParErr_r;
   reg [11:0] rxE0_r, rxE1_r;
   reg [1:0]  rxCount_r;

   wire [2:0] character_size_field   = ctrlC_r[2:0];
   wire [1:0] parMode  = ctrlC_r[5:4];
   wire       syncMode = ctrlC_r[`SFTR_CC_SYNC];
   wire       txEnReq  = ctrlB_r[`SFTR_CB_TXEN];
   wire       rxEn     = ctrlB_r[`SFTR_CB_RXEN];
   wire       inv      = pinCtrl_r[`SFTR_PC_INV];
   wire       master   = pinCtrl_r[`SFTR_PC_XCKOUT];
   wire [3:0] nBits    = charBits(character_size_field);
   wire [4:0] spb      = syncMode ? `SFTR_S_SYNC :
                         (ctrlB_r[3:2] == `SFTR_RXM_DOUBLE) ? `SFTR_S_DOUBLE
                                                            : `SFTR_S_NORMAL;
   wire [4:0] mid      = {1'b0, spb[4:1]};

   // avalon slave: reads answer one cycle late so readdata comes from a flop
   assign waitrequest = read & ~rdAck_r;
   wire   rdTake = read & rdAck_r;
   wire   wrTake = write;
   wire   rdLow  = rdTake && address == `SFTR_OFF_RXLOW;
   wire   rdHigh = rdTake && address == `SFTR_OFF_RXHIGH;
   wire   nineLowFirst = (character_size_field == `SFTR_CH_9LOWFIRST);
   wire   rxPop = (rxCount_r != 2'd0) &&
                  (nineLowFirst ? rdHigh : rdLow);

   // fractional sample tick: one tick per BAUD/64 clocks on average
   wire [16:0] accSum = baudAcc_r + `SFTR_BAUD_ONE;
   wire        tick   = accSum >= {1'b0, baud_r};

   // transfer clock: edges taken from the generated clock as master, from the synchronised pin as slave
   wire tclkLvl   = master ? tclkGen_r : tclkB_r;
   wire tclkRise  = tclkLvl & ~tclkPrev_r;
   wire tclkFall  = ~tclkLvl & tclkPrev_r;
   wire launchEdg = inv ? tclkFall : tclkRise;
   wire sampleEdg = inv ? tclkRise : tclkFall;
   assign tclkOut = tclkGen_r;
   assign tclkOe  = syncMode & master;

   // transmitter
   wire txActive = txEnReq | txBusy_r | txBufFull_r;
   wire txStep   = syncMode ? launchEdg : (tick && txPh_r == spb - 5'd1);
   wire txLast   = txBusy_r && txStep && txCnt_r == 4'd1;
   wire txLoad   = txBufFull_r && (!txBusy_r || txLast);
   wire [3:0] txLen = 4'd2 + nBits + {3'b0, parMode[1]} + {3'b0, ctrlC_r[`SFTR_CC_STOP2]};
   assign txdOut = txBusy_r ? txSh_r[0] : 1'b1;
   assign txdOe  = txActive;

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         txBuf_r     <= 9'h000;
         txBufFull_r <= 1'b0;
         txBusy_r    <= 1'b0;
         txSh_r      <= 13'h1FFF;
         txCnt_r     <= 4'h0;
         txPh_r      <= 5'h00;
         txc_r       <= 1'b0;
      end else begin
         if (wrTake && address == `SFTR_OFF_TXHIGH)
            txBuf_r[8] <= writedata[0];
         if (wrTake && address == `SFTR_OFF_TXLOW && txEnReq && !txBufFull_r)
            txBuf_r[7:0] <= writedata[7:0];
         if (wrTake && address == `SFTR_OFF_TXLOW && txEnReq && !txBufFull_r)
            txBufFull_r <= 1'b1;
         else if (txLoad)
            txBufFull_r <= 1'b0;
         if (txLoad) begin
            txSh_r   <= txFrame(txBuf_r, character_size_field, parMode);
            txCnt_r  <= txLen;
            txBusy_r <= 1'b1;
            txPh_r   <= 5'h00;
         end else if (txBusy_r) begin
            if (tick && !syncMode)
               txPh_r <= (txPh_r == spb - 5'd1) ? 5'h00 : txPh_r + 5'd1;
            if (txStep) begin
               txSh_r  <= {1'b1, txSh_r[12:1]};
               txCnt_r <= txCnt_r - 4'd1;
               if (txCnt_r == 4'd1)
                  txBusy_r <= 1'b0;
            end
         end
         // a completion in the clearing cycle wins over the clear
         if (txLast && !txBufFull_r)
            txc_r <= 1'b1;
         else if (wrTake && address == `SFTR_OFF_STATUS && writedata[`SFTR_ST_TXC])
            txc_r <= 1'b0;
      end
   end

   // receiver bit decision
   wire       rxBit   = rxB_r;
   wire       vote    = (rxOnes_r + {1'b0, rxBit}) >= 2'd2;
   wire       asyncDec = !syncMode && tick && rxState_r != RX_IDLE && rxPh_r == mid + 5'd2;
   wire       syncDec  = syncMode && sampleEdg && rxState_r != RX_IDLE;
   wire       rxDec   = asyncDec | syncDec;
   wire       bitVal  = syncMode ? rxBit : vote;
   wire       rxPush  = rxEn && rxDec && rxState_r == RX_STOP;
   wire [8:0] receive_buffer_head  = rxSh_r >> (4'd9 - nBits);
   wire [11:0] rxNew  = {1'b0, ~bitVal, rxParErr_r, receive_buffer_head};

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rxState_r <= RX_IDLE;
         rxPh_r    <= 5'h00;
         rxOnes_r  <= 2'h0;
         rxIdx_r   <= 4'h0;
         rxSh_r    <= 9'h000;
         rxPar_r   <= 1'b0;
         rxParErr_r <= 1'b0;
      end else if (!rxEn) begin
         rxState_r <= RX_IDLE;
         rxPh_r    <= 5'h00;
      end else begin
         if (!syncMode && tick && rxState_r != RX_IDLE) begin
            rxPh_r <= (rxPh_r == spb) ? 5'h01 : rxPh_r + 5'd1;
            if (rxPh_r == spb)
               rxOnes_r <= 2'h0;
            else if ((rxPh_r == mid || rxPh_r == mid + 5'd1) && rxBit)
               rxOnes_r <= rxOnes_r + 2'd1;
         end
         case (rxState_r)
            RX_IDLE: begin
               rxPar_r    <= parMode[0];
               rxParErr_r <= 1'b0;
               rxIdx_r  <= 4'h0;
               rxOnes_r <= 2'h0;
               if (syncMode && sampleEdg && !rxBit)
                  rxState_r <= RX_DATA;
               else if (!syncMode && tick && !rxBit) begin
                  rxState_r <= RX_START;
                  rxPh_r    <= 5'h02;
               end
            end
            RX_START: if (rxDec)
               rxState_r <= bitVal ? RX_IDLE : RX_DATA;
            RX_DATA: if (rxDec) begin
               rxSh_r  <= {bitVal, rxSh_r[8:1]};
               rxPar_r <= rxPar_r ^ bitVal;
               rxIdx_r <= rxIdx_r + 4'd1;
               if (rxIdx_r == nBits - 4'd1)
                  rxState_r <= parMode[1] ? RX_PAR : RX_STOP;
            end
            RX_PAR: if (rxDec) begin
               rxParErr_r <= rxPar_r ^ bitVal;
               rxState_r  <= RX_STOP;
            end
            RX_STOP: if (rxDec)
               rxState_r <= RX_IDLE;
            default: rxState_r <= RX_IDLE;
         endcase
      end
   end

   // two-entry receive buffer; a full buffer overwrites its newest entry
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rxE0_r    <= 12'h000;
         rxE1_r    <= 12'h000;
         rxCount_r <= 2'h0;
      end else if (!rxEn) begin
         rxCount_r <= 2'h0;
      end else begin
         case ({rxPush, rxPop})
            2'b01: begin
               rxE0_r    <= rxE1_r;
               rxCount_r <= rxCount_r - 2'd1;
            end
            2'b10: begin
               if (rxCount_r == 2'd0)
                  rxE0_r <= rxNew;
               else if (rxCount_r == 2'd1)
                  rxE1_r <= rxNew;
               else
                  rxE1_r <= rxNew | 12'h800;
               if (rxCount_r != 2'd2)
                  rxCount_r <= rxCount_r + 2'd1;
            end
            2'b11: begin
               if (rxCount_r == 2'd1)
                  rxE0_r <= rxNew;
               else begin
                  rxE0_r <= rxE1_r;
                  rxE1_r <= rxNew;
               end
            end
            default: rxCount_r <= rxCount_r;
         endcase
      end
   end

   wire rxc = rxCount_r != 2'd0;

   // control registers, pin synchronisers, transfer clock generator
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrlB_r   <= `SFTR_RST_CTRLB;
         ctrlC_r   <= `SFTR_RST_CTRLC;
         pinCtrl_r <= `SFTR_RST_PINCTRL;
         baud_r    <= `SFTR_RST_BAUD;
         baudAcc_r <= 17'h0_0000;
         rdAck_r   <= 1'b0;
         rxA_r     <= 1'b1;
         rxB_r     <= 1'b1;
         tclkA_r    <= 1'b0;
         tclkB_r    <= 1'b0;
         tclkPrev_r <= 1'b0;
         tclkGen_r  <= 1'b0;
      end else begin
         rdAck_r   <= read & ~rdAck_r;
         rxA_r     <= rxdIn;
         rxB_r     <= rxA_r;
         tclkA_r    <= tclkIn;
         tclkB_r    <= tclkA_r;
         tclkPrev_r <= tclkLvl;
         baudAcc_r <= tick ? accSum - {1'b0, baud_r} : accSum;
         // master clock toggles on every tick: two samples per bit
         if (syncMode && master && tick)
            tclkGen_r <= ~tclkGen_r;
         if (wrTake) begin
            case (address)
               `SFTR_OFF_CTRLB:   ctrlB_r   <= writedata[7:0];
               `SFTR_OFF_CTRLC:   ctrlC_r   <= writedata[7:0];
               `SFTR_OFF_PINCTRL: pinCtrl_r <= writedata[7:0];
               // below 64 the divider would exceed the clock; clamp
               `SFTR_OFF_BAUD:    baud_r    <= (writedata[15:0] < 16'h0040) ?
                                               16'h0040 : writedata[15:0];
               default:           baud_r    <= baud_r;
            endcase
         end
      end
   end

   // read data register; unmapped addresses read zero
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         readdata <= 32'h0000_0000;
      else if (read && !rdAck_r) begin
         case (address)
            `SFTR_OFF_RXLOW:   readdata <= {24'h00_0000, rxE0_r[7:0]};
            `SFTR_OFF_RXHIGH:  readdata <= {24'h00_0000, rxc, 3'b000, rxE0_r[11:8]};
            `SFTR_OFF_STATUS:  readdata <= {24'h00_0000, rxc, txc_r, ~txBufFull_r, 5'h00};
            `SFTR_OFF_CTRLB:   readdata <= {24'h00_0000, ctrlB_r};
            `SFTR_OFF_CTRLC:   readdata <= {24'h00_0000, ctrlC_r};
            `SFTR_OFF_BAUD:    readdata <= {16'h0000, baud_r};
            `SFTR_OFF_PINCTRL: readdata <= {24'h00_0000, pinCtrl_r};
            default:           readdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule // sftr_datapath

/* File: testbench/sftr_datapath_properties.sv */
// port-level checker for the serial frame datapath
`timescale 1ns/1ps
`include "sftr_consts.vh"
module sftr_datapath_properties (
   input wire        sys_clk,
   input wire        rstn,
   input wire [5:0]  address,
   input wire        read,
   input wire        write,
   input wire [31:0] writedata,
   input wire [31:0] readdata,
   input wire        waitrequest,
   input wire        rxdIn,
   input wire        txdOut,
   input wire        txdOe,
   input wire        tclkIn,
   input wire        tclkOut,
   input wire        tclkOe
);
   // shadow of the mode bits, rebuilt from bus writes only
   reg sync_r;
   reg mast_r;
   reg dbl_r;
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sync_r <= 1'b0;
         mast_r <= 1'b0;
         dbl_r  <= 1'b0;
      end else if (write && !waitrequest) begin
         if (address == `SFTR_OFF_CTRLC) sync_r <= writedata[`SFTR_CC_SYNC];
         if (address == `SFTR_OFF_PINCTRL) mast_r <= writedata[`SFTR_PC_XCKOUT];
         if (address == `SFTR_OFF_CTRLB) dbl_r <= (writedata[3:2] == `SFTR_RXM_DOUBLE);
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wait_read_a: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
      else $error("read answer not in second cycle");
   write_nowait_a: assert property (write |-> !waitrequest)
      else $error("write stalled");
   read_hold_a: assert property (!read |=> $stable(readdata))
      else $error("read data changed without a read");
   unmapped_zero_a: assert property (read && !waitrequest && address > 6'h20 |-> readdata == 0)
      else $error("unmapped read not zero");
   idle_high_a: assert property (!txdOe |-> txdOut)
      else $error("released line not high");
   start_len_a: assert property ($fell(txdOut) && !sync_r && !dbl_r |-> !txdOut[*8] ##1 !txdOut[*8])
      else $error("start bit shorter than sixteen ticks");
   oe_release_a: assert property ($fell(txdOe) |-> $past(txdOut))
      else $error("pin released inside a frame");
   clock_role_a: assert property (tclkOe == (sync_r && mast_r))
      else $error("clock pin direction wrong");
   cover property ($fell(txdOe));
   cover property (tclkOe);
   cover property ($fell(txdOut));
endmodule // sftr_datapath_properties
bind sftr_datapath sftr_datapath_properties sftr_datapath_properties_inst (.sys_clk(sys_clk),
   .rstn(rstn), .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest), .rxdIn(rxdIn), .txdOut(txdOut),
   .txdOe(txdOe), .tclkIn(tclkIn), .tclkOut(tclkOut), .tclkOe(tclkOe));

/* File: testbench/sftr_remote_model.sv */
// remote transceiver: async frames both ways, sync slave-side clock and data
`timescale 1ns/1ps
module sftr_remote_model (
   input  wire       sys_clk,
   input  wire       txd,
   input  wire       txdOe,
   input  wire [3:0] nBits,
   input  wire       parEn,
   output reg        rxd,
   output reg        tclk,
   output reg  [8:0] rxWord,
   output reg  [7:0] rxCount
);
   integer i;
   initial begin
      rxd = 1'b1;
      tclk = 1'b0;
      rxWord = 9'h000;
      rxCount = 8'h00;
   end
   task automatic drive(input b, input integer t);
      @(posedge sys_clk);
      rxd <= b;
      repeat (t - 1) @(posedge sys_clk);
   endtask
   task automatic sendAsync(input [8:0] d, input par, input stp, input integer t);
      integer k;
      drive(1'b0, t);
      for (k = 0; k < nBits; k++) drive(d[k], t);
      if (parEn) drive(par, t);
      drive(stp, t);
      drive(1'b1, 3 * t);
   endtask
   // clock stands at the idle level outside frames
   task automatic sendSync(input [7:0] d, input inv);
      integer k;
      reg [9:0] f;
      f = {1'b1, d, 1'b0};
      tclk <= inv;
      repeat (8) @(posedge sys_clk);
      for (k = 0; k < 10; k++) begin
         rxd <= f[k];
         tclk <= ~inv;
         repeat (4) @(posedge sys_clk);
         tclk <= inv;
         repeat (4) @(posedge sys_clk);
      end
   endtask
   // mid-bit sampling of the device's transmit line at sixteen ticks per bit
   initial forever begin
      @(posedge sys_clk);
      if (txdOe && !txd) begin
         rxWord <= 9'h000;
         repeat (8) @(posedge sys_clk);
         for (i = 0; i < nBits; i++) begin
            repeat (16) @(posedge sys_clk);
            rxWord[i] <= txd;
         end
         repeat (16) @(posedge sys_clk);
         rxCount <= rxCount + 8'h01;
      end
   end
endmodule // sftr_remote_model

/* File: testbench/sftr_datapath_tb.sv */
// register-level tests of the serial frame datapath
`timescale 1ns/1ps
`include "sftr_consts.vh"
module sftr_datapath_tb;
   reg         sys_clk = 1'b0;
   reg         rstn = 1'b0;
   reg  [5:0]  address = 6'h00;
   reg         read = 1'b0;
   reg         write = 1'b0;
   reg  [31:0] writedata = 32'h0000_0000;
   reg  [3:0]  nBits = 4'h8;
   reg         parEn = 1'b0;
   wire [31:0] readdata;
   wire        waitrequest, rxdIn, txdOut, txdOe, tclkIn, tclkOut, tclkOe;
   wire [8:0]  rxWord;
   wire [7:0]  rxCount;
   integer     nErrors = 0;
   integer     samplesChecked = 0;
   integer     m;
   reg  [7:0]  c;
   always #10 sys_clk = ~sys_clk;
   sftr_datapath sftr_datapath_inst (.sys_clk(sys_clk), .rstn(rstn), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .rxdIn(rxdIn), .txdOut(txdOut), .txdOe(txdOe),
      .tclkIn(tclkIn), .tclkOut(tclkOut), .tclkOe(tclkOe));
   sftr_remote_model sftr_remote_model_inst (.sys_clk(sys_clk), .txd(txdOut), .txdOe(txdOe),
      .nBits(nBits), .parEn(parEn), .rxd(rxdIn), .tclk(tclkIn), .rxWord(rxWord),
      .rxCount(rxCount));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         nErrors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input [5:0] a, input [31:0] d);
      @(posedge sys_clk);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      // the write lands at the rising edge that sees waitrequest low
      do @(posedge sys_clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask
   task automatic rdChk(input [5:0] a, input [31:0] mask, input [31:0] exp);
      logic [31:0] d;
      @(posedge sys_clk);
      address <= a;
      read <= 1'b1;
      do @(posedge sys_clk); while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
      chk(d & mask, exp);
   endtask
   task automatic waitWord(input [7:0] n, input [8:0] e);
      while (rxCount == n) @(posedge sys_clk);
      chk({23'h0, rxWord}, {23'h0, e});
   endtask
   task automatic rxErr(input [8:0] d, input p, input s, input [31:0] e);
      sftr_remote_model_inst.sendAsync(d, p, s, 16);
      rdChk(`SFTR_OFF_RXHIGH, 32'h8E, e);
      rdChk(`SFTR_OFF_RXLOW, 32'hFF, {24'h0, d[7:0]});
   endtask
   task report_and_stop;
      $display("errors %0d, checks %0d", nErrors, samplesChecked);
      if (nErrors == 0 && samplesChecked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      nErrors++;
      report_and_stop;
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      rdChk(`SFTR_OFF_CTRLC, 32'hFF, 32'h03);
      rdChk(`SFTR_OFF_BAUD, 32'hFFFF, 32'h40);
      rdChk(`SFTR_OFF_STATUS, 32'hE0, 32'h20);
      rdChk(6'h3C, 32'hFFFF_FFFF, 32'h0);
      wr(`SFTR_OFF_CTRLB, 32'h3);
      c = rxCount;
      wr(`SFTR_OFF_TXLOW, 32'h3C);
      wr(`SFTR_OFF_TXLOW, 32'hC3);
      rdChk(`SFTR_OFF_STATUS, 32'h60, 32'h0);
      waitWord(c, 9'h03C);
      waitWord(c + 8'h01, 9'h0C3);
      repeat (24) @(posedge sys_clk);
      rdChk(`SFTR_OFF_STATUS, 32'h60, 32'h60);
      wr(`SFTR_OFF_STATUS, 32'h40);
      rdChk(`SFTR_OFF_STATUS, 32'h40, 32'h0);
      wr(`SFTR_OFF_CTRLC, 32'h0);
      nBits <= 4'h5;
      c = rxCount;
      wr(`SFTR_OFF_TXLOW, 32'hFF);
      waitWord(c, 9'h01F);
      sftr_remote_model_inst.sendAsync(9'h035, 1'b0, 1'b1, 16);
      rdChk(`SFTR_OFF_RXLOW, 32'hFFFF_FFFF, 32'h15);
      nBits <= 4'h8;
      parEn <= 1'b1;
      wr(`SFTR_OFF_CTRLC, 32'h23);
      rxErr(9'h001, 1'b1, 1'b1, 32'h80);
      rxErr(9'h001, 1'b0, 1'b1, 32'h82);
      wr(`SFTR_OFF_CTRLC, 32'h33);
      rxErr(9'h001, 1'b0, 1'b1, 32'h80);
      parEn <= 1'b0;
      wr(`SFTR_OFF_CTRLC, 32'h03);
      rxErr(9'h055, 1'b0, 1'b0, 32'h84);
      sftr_remote_model_inst.sendAsync(9'h011, 1'b0, 1'b1, 16);
      sftr_remote_model_inst.sendAsync(9'h022, 1'b0, 1'b1, 16);
      sftr_remote_model_inst.sendAsync(9'h033, 1'b0, 1'b1, 16);
      rdChk(`SFTR_OFF_RXHIGH, 32'h8F, 32'h80);
      rdChk(`SFTR_OFF_RXLOW, 32'hFF, 32'h11);
      rdChk(`SFTR_OFF_RXHIGH, 32'h8F, 32'h88);
      rdChk(`SFTR_OFF_RXLOW, 32'hFF, 32'h33);
      rdChk(`SFTR_OFF_RXHIGH, 32'h80, 32'h0);
      for (m = 0; m < 4; m++) begin
         wr(`SFTR_OFF_CTRLB, (m << 2) | 3);
         sftr_remote_model_inst.sendAsync(9'h05A + m, 1'b0, 1'b1, (m == 1) ? 8 : 16);
         rdChk(`SFTR_OFF_RXLOW, 32'hFF, 32'h5A + m);
      end
      sftr_remote_model_inst.sendAsync(9'h077, 1'b0, 1'b1, 16);
      wr(`SFTR_OFF_CTRLB, 32'h1);
      rdChk(`SFTR_OFF_RXHIGH, 32'h80, 32'h0);
      c = rxCount;
      wr(`SFTR_OFF_TXLOW, 32'h96);
      wr(`SFTR_OFF_CTRLB, 32'h2);
      waitWord(c, 9'h096);
      repeat (24) @(negedge sys_clk);
      chk({31'h0, txdOe}, 32'h0);
      wr(`SFTR_OFF_CTRLB, 32'h3);
      nBits <= 4'h9;
      wr(`SFTR_OFF_CTRLC, 32'h06);
      sftr_remote_model_inst.sendAsync(9'h1A5, 1'b0, 1'b1, 16);
      rdChk(`SFTR_OFF_RXLOW, 32'hFF, 32'hA5);
      rdChk(`SFTR_OFF_RXHIGH, 32'h81, 32'h81);
      rdChk(`SFTR_OFF_RXHIGH, 32'h80, 32'h0);
      wr(`SFTR_OFF_CTRLC, 32'h07);
      c = rxCount;
      wr(`SFTR_OFF_TXHIGH, 32'h1);
      wr(`SFTR_OFF_TXLOW, 32'h5A);
      waitWord(c, 9'h15A);
      sftr_remote_model_inst.sendAsync(9'h1C3, 1'b0, 1'b1, 16);
      rdChk(`SFTR_OFF_RXHIGH, 32'h8F, 32'h81);
      rdChk(`SFTR_OFF_RXLOW, 32'hFF, 32'hC3);
      nBits <= 4'h8;
      wr(`SFTR_OFF_CTRLC, 32'h43);
      sftr_remote_model_inst.sendSync(8'h9C, 1'b0);
      rdChk(`SFTR_OFF_RXLOW, 32'hFF, 32'h9C);
      wr(`SFTR_OFF_PINCTRL, 32'h1);
      sftr_remote_model_inst.sendSync(8'h6B, 1'b1);
      rdChk(`SFTR_OFF_RXLOW, 32'hFF, 32'h6B);
      wr(`SFTR_OFF_PINCTRL, 32'h2);
      @(negedge sys_clk);
      chk({31'h0, tclkOe}, 32'h1);
      c[0] = tclkOut;
      @(negedge sys_clk);
      chk({31'h0, tclkOut}, {31'h0, ~c[0]});
      wr(`SFTR_OFF_PINCTRL, 32'h0);
      report_and_stop;
   end
endmodule // sftr_datapath_tb
